/* shared/cls_cfg_if.sv */
`timescale 1ns/1ps
interface cls_cfg_if;
   logic [cls_pkg::ADDR_W-1:0] latchAddr;
   logic [cls_pkg::DATA_W-1:0] latchData;
   logic latchWriteStrobeN;
   modport dev(
      input latchAddr,
      input latchData,
      input latchWriteStrobeN
   );
   modport host(
      output latchAddr,
      output latchData,
      output latchWriteStrobeN
   );
endinterface

/* shared/cls_pkg.sv */
// Notes on behaviour
// - selftest enabled: LFSR makes 511-character sequence
// - synced checker compares each character, reports status
// - loop end shows 010b or 100b once
// - mismatches beyond matches by 16: abort, wait
// - PLL lock loss forces pattern start state
// - reset presets selftest select to disabled
// - rx power latch 0 disables PLL, analog
// - two tx and two reclock driver latches
// - cleared driver off; both off, logic off
// - both reclock drivers off: reclocker off only
// - reset initializes every machine, counter, latch
// - host also resets the boundary-scan controller
// - host writes enabling latches after every reset
// - six write-only seven-bit banks, no readback
// - strobe low captures data into addressed bank
// - banks 0 to 2 hold receive channel
// - static, dynamic and test bank address groups
// - host drives fixed bits with required values
// - rate latch resets 1: half-rate clock out
// - half rate: capture on alternate clock edges
// - selftest select resets 11; 01 off, 10 on
// - reclock driver latches reset 0, 1 enables
package cls_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 7;
   localparam int CHAR_W = 10;
   localparam int NUM_BANKS = 6;

   // bank addresses, index order of the storage
   localparam logic [ADDR_W-1:0] BANK_ADDR [NUM_BANKS] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
   localparam logic [DATA_W-1:0] BANK_RESET [NUM_BANKS] = '{7'h00, 7'h01, 7'h18, 7'h00, 7'h00, 7'h00};
   localparam logic [ADDR_W-1:0] TEST_ADDR_A = 3'h3;
   localparam logic [ADDR_W-1:0] TEST_ADDR_B = 3'h4;

   // field positions
   localparam int RATE_IDX = 1;
   localparam int RATE_BIT = 0;
   localparam int RXDYN_IDX = 2;
   localparam int RX_POWER_BIT = 0;
   localparam int RECLK1_BIT = 1;
   localparam int RECLK2_BIT = 2;
   localparam int SELFTEST_LSB = 3;
   localparam int TXDYN_IDX = 5;
   localparam int TX1_BIT = 0;
   localparam int TX2_BIT = 1;

   // selftest select encodings
   localparam logic [1:0] SEL_OFF = 2'h1;
   localparam logic [1:0] SEL_ON = 2'h2;

   // checker
   localparam int LFSR_W = 9;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 9'h1ff;
   localparam int TAP_A = 8;
   localparam int TAP_B = 4;
   localparam logic [8:0] SEQ_LAST = 9'h1fe;
   localparam logic [4:0] ABORT_DIFF = 5'h10;

   // status codes {status bit, data bit 0, data bit 1}
   localparam logic [2:0] ST_MATCH = 3'h0;
   localparam logic [2:0] ST_MISS = 3'h1;
   localparam logic [2:0] ST_LOOP_GOOD = 3'h2;
   localparam logic [2:0] ST_WAIT = 3'h3;
   localparam logic [2:0] ST_LOOP_BAD = 3'h4;

   typedef enum logic [1:0] {
      CHK_START = 2'b00,
      CHK_WAIT = 2'b01,
      CHK_COMPARE = 2'b11
   } cls_chk_state_t;

   // host side
   localparam logic [1:0] HREG_WRITE = 2'h0;
   localparam logic [1:0] HREG_STATUS = 2'h1;
   localparam logic [1:0] HREG_LAST = 2'h2;
   localparam logic [3:0] JTAG_RESET_CYCLES = 4'h8;
   localparam logic [DATA_W-1:0] FIX_MASK = 7'h60;
   localparam logic [DATA_W-1:0] FIX_VALUE = 7'h00;
   localparam int BOOT_LEN = 3;
   localparam logic [9:0] BOOT_TABLE [BOOT_LEN] = '{10'h081, 10'h10f, 10'h383};

   typedef enum logic [1:0] {
      HW_IDLE = 2'b00,
      HW_SETUP = 2'b01,
      HW_STROBE = 2'b11,
      HW_HOLD = 2'b10
   } cls_host_state_t;

   function automatic logic [LFSR_W-1:0] cls_lfsr_next(input logic [LFSR_W-1:0] s);
      return {s[LFSR_W-2:0], s[TAP_A] ^ s[TAP_B]};
   endfunction

   function automatic logic [CHAR_W-1:0] cls_lfsr_char(input logic [LFSR_W-1:0] s);
      return {s, s[TAP_A] ^ s[TAP_B]};
   endfunction
endpackage

/* sim/cls_cfg_properties.sv */
`timescale 1ns/1ps
module cls_cfg_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [cls_pkg::ADDR_W-1:0] latchAddr,
   input wire logic [cls_pkg::DATA_W-1:0] latchData,
   input wire logic latchWriteStrobeN,
   input wire logic [cls_pkg::CHAR_W-1:0] rxParallelOut,
   input wire logic selftestStatusBit,
   input wire logic rxChannelPowerOn,
   input wire logic txPrimaryDriverOn,
   input wire logic txSecondaryDriverOn,
   input wire logic txLogicOn,
   input wire logic reclkPrimaryDriverOn,
   input wire logic reclkSecondaryDriverOn,
   input wire logic reclkLogicOn,
   input wire logic rxClockRateSelect,
   input wire logic recoveredClockOutP,
   input wire logic recoveredClockOutN
);
   import cls_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_strobe_one_cycle: assert property ($fell(latchWriteStrobeN) |=> $rose(latchWriteStrobeN))
      else $error("write strobe not one cycle");
   chk_addr_data_hold: assert property ($fell(latchWriteStrobeN) |->
      $stable(latchAddr) && $stable(latchData) ##1 $stable(latchAddr) && $stable(latchData))
      else $error("address or data moved around strobe");
   chk_fixed_bits: assert property (!latchWriteStrobeN |-> (latchData & FIX_MASK) == FIX_VALUE)
      else $error("fixed bits wrong");
   chk_tx_logic_power: assert property (txLogicOn == (txPrimaryDriverOn | txSecondaryDriverOn))
      else $error("tx logic power wrong");
   chk_reclk_logic_power: assert property (
      reclkLogicOn == (rxChannelPowerOn & (reclkPrimaryDriverOn | reclkSecondaryDriverOn)))
      else $error("reclock logic power wrong");
   chk_half_rate_clock: assert property (resetn && $past(resetn) && rxClockRateSelect && $past(rxClockRateSelect) |->
      recoveredClockOutP != $past(recoveredClockOutP) && recoveredClockOutN == !recoveredClockOutP)
      else $error("half rate clock not toggling");
   chk_full_rate_idle: assert property (!rxClockRateSelect |-> !recoveredClockOutP && !recoveredClockOutN)
      else $error("clock outputs not idle");
   chk_tx_bank_write: assert property (!latchWriteStrobeN && latchAddr == 3'h7 |-> ##2
      txPrimaryDriverOn == $past(latchData[TX1_BIT], 2) && txSecondaryDriverOn == $past(latchData[TX2_BIT], 2))
      else $error("tx driver latch not applied");
   chk_rx_bank_write: assert property (!latchWriteStrobeN && latchAddr == 3'h2 |-> ##2
      rxChannelPowerOn == $past(latchData[RX_POWER_BIT], 2)
      && reclkPrimaryDriverOn == $past(latchData[RECLK1_BIT], 2))
      else $error("rx bank latch not applied");
   chk_loop_bad_once: assert property (selftestStatusBit |->
      rxParallelOut[1:0] == 2'h0 ##1 !selftestStatusBit)
      else $error("bad loop mark wrong");
endmodule

/* sim/tb_config_latches_rx_selftest.sv */
`timescale 1ns/1ps
module tb_config_latches_rx_selftest;
   import cls_pkg::*;
   logic clk, resetn, regWr, regRd, rxPllLocked, jtagResetN;
   logic [1:0] regAddr;
   logic [15:0] regWrData, regRdData, st;
   logic [9:0] rxChar, rxParallelOut;
   logic selftestStatusBit, rxChannelPowerOn, txPrimaryDriverOn, txSecondaryDriverOn, txLogicOn;
   logic reclkPrimaryDriverOn, reclkSecondaryDriverOn, reclkLogicOn;
   logic rxClockRateSelect, recoveredClockOutP, recoveredClockOutN;
   logic [8:0] lfsr;
   logic [2:0] lastCode;
   int failCount = 0;
   int testsRun = 0;
   int cnt [8];
   cls_cfg_if cfgLink();
   cls_host u_cls_host(.clk(clk), .resetn(resetn), .cfg(cfgLink.host), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .jtagResetN(jtagResetN));
   cls_device u_cls_device(.clk(clk), .resetn(resetn), .cfg(cfgLink.dev), .rxChar(rxChar),
      .rxPllLocked(rxPllLocked), .rxParallelOut(rxParallelOut), .selftestStatusBit(selftestStatusBit),
      .rxChannelPowerOn(rxChannelPowerOn), .txPrimaryDriverOn(txPrimaryDriverOn),
      .txSecondaryDriverOn(txSecondaryDriverOn), .txLogicOn(txLogicOn),
      .reclkPrimaryDriverOn(reclkPrimaryDriverOn), .reclkSecondaryDriverOn(reclkSecondaryDriverOn),
      .reclkLogicOn(reclkLogicOn), .rxClockRateSelect(rxClockRateSelect),
      .recoveredClockOutP(recoveredClockOutP), .recoveredClockOutN(recoveredClockOutN));
   cls_cfg_properties u_cls_cfg_properties(.clk(clk), .resetn(resetn), .latchAddr(cfgLink.latchAddr),
      .latchData(cfgLink.latchData), .latchWriteStrobeN(cfgLink.latchWriteStrobeN),
      .rxParallelOut(rxParallelOut), .selftestStatusBit(selftestStatusBit),
      .rxChannelPowerOn(rxChannelPowerOn), .txPrimaryDriverOn(txPrimaryDriverOn),
      .txSecondaryDriverOn(txSecondaryDriverOn), .txLogicOn(txLogicOn),
      .reclkPrimaryDriverOn(reclkPrimaryDriverOn), .reclkSecondaryDriverOn(reclkSecondaryDriverOn),
      .reclkLogicOn(reclkLogicOn), .rxClockRateSelect(rxClockRateSelect),
      .recoveredClockOutP(recoveredClockOutP), .recoveredClockOutN(recoveredClockOutN));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic close_out();
      $display("compares %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      d = regRdData;
   endtask
   task automatic cfg_write(input logic [2:0] b, input logic [6:0] d);
      reg_write(2'h0, {6'h00, b, d});
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask
   // drives either the pattern or all-zero characters, tallies status codes
   task automatic feed(input int n, input logic good);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rxChar <= good ? {lfsr, lfsr[8] ^ lfsr[4]} : 10'h000;
         if (good) lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
         @(negedge clk);
         lastCode = {selftestStatusBit, rxParallelOut[0], rxParallelOut[1]};
         if (^lastCode !== 1'bx) cnt[lastCode]++;
      end
   endtask
   task automatic clear_cnt();
      foreach (cnt[i]) cnt[i] = 0;
      lfsr = 9'h1ff;
   endtask
   task automatic t_reset_values();
      @(negedge clk);
      chk_bit("jtag reset", 1'b0, jtagResetN);
      chk_bit("rate", 1'b1, rxClockRateSelect);
      chk_bit("reclk1", 1'b0, reclkPrimaryDriverOn);
      chk_bit("reclk2", 1'b0, reclkSecondaryDriverOn);
      chk_bit("rx power", 1'b0, rxChannelPowerOn);
      chk_bit("status bit", 1'b0, selftestStatusBit);
      chk_bit("tx logic", 1'b0, txLogicOn);
   endtask
   task automatic t_boot();
      for (int i = 0; i < 40; i++) begin
         reg_read(2'h1, st);
         if (st[1] === 1'b1) break;
      end
      repeat (8) @(negedge clk);
      chk_bit("jtag released", 1'b1, jtagResetN);
      chk_bit("boot done", 1'b1, st[1]);
      chk_bit("rx power", 1'b1, rxChannelPowerOn);
      chk_bit("reclk1", 1'b1, reclkPrimaryDriverOn);
      chk_bit("reclk2", 1'b1, reclkSecondaryDriverOn);
      chk_bit("tx2", 1'b1, txSecondaryDriverOn);
      reg_read(2'h2, st);
      chk_word("last write", 16'h0383, st);
   endtask
   task automatic t_refused();
      reg_write(2'h0, 16'h0381);
      reg_write(2'h0, 16'h0382);
      repeat (8) @(posedge clk);
      reg_read(2'h1, st);
      chk_bit("refused", 1'b1, st[2]);
      reg_read(2'h1, st);
      chk_bit("refused cleared", 1'b0, st[2]);
      reg_read(2'h2, st);
      chk_word("last write", 16'h0381, st);
      reg_read(2'h3, st);
      chk_word("unmapped", 16'h0000, st);
      chk_bit("tx1", 1'b1, txPrimaryDriverOn);
      chk_bit("tx2", 1'b0, txSecondaryDriverOn);
      chk_bit("tx logic", 1'b1, txLogicOn);
   endtask
   task automatic t_drivers();
      cfg_write(3'h7, 7'h00);
      chk_bit("tx1 off", 1'b0, txPrimaryDriverOn);
      chk_bit("tx logic off", 1'b0, txLogicOn);
      @(posedge clk);
      rxChar <= 10'h2a5;
      cfg_write(3'h2, 7'h09);
      chk_bit("reclk logic off", 1'b0, reclkLogicOn);
      chk_bit("rx power", 1'b1, rxChannelPowerOn);
      chk_word("parallel out", 16'h02a5, {6'h00, rxParallelOut});
      cfg_write(3'h3, 7'h00);
      cfg_write(3'h4, 7'h00);
      chk_bit("test bank ignored", 1'b1, rxChannelPowerOn);
      cfg_write(3'h2, 7'h0f);
      chk_bit("reclk logic on", 1'b1, reclkLogicOn);
   endtask
   task automatic t_rate();
      logic p;
      cfg_write(3'h1, 7'h00);
      chk_bit("rate", 1'b0, rxClockRateSelect);
      chk_bit("clock idle", 1'b0, recoveredClockOutP | recoveredClockOutN);
      cfg_write(3'h1, 7'h01);
      p = recoveredClockOutP;
      @(negedge clk);
      chk_bit("clock toggles", ~p, recoveredClockOutP);
   endtask
   task automatic t_loop();
      cfg_write(3'h2, 7'h17);
      clear_cnt();
      feed(10, 1'b0);
      clear_cnt();
      feed(1030, 1'b1);
      chk_word("loop good marks", 16'h0002, cnt[2][15:0]);
      chk_word("mismatches", 16'h0000, cnt[1][15:0]);
      chk_word("loop bad marks", 16'h0000, cnt[4][15:0]);
      chk_bit("matches", 1'b1, cnt[0] >= 1020);
   endtask
   task automatic t_abort();
      clear_cnt();
      feed(25, 1'b0);
      chk_word("mismatches", 16'h0011, cnt[1][15:0]);
      chk_word("wait code", 16'h0003, {13'h0000, lastCode});
   endtask
   task automatic t_lock_loss();
      clear_cnt();
      feed(40, 1'b1);
      chk_word("resync mismatches", 16'h0000, cnt[1][15:0]);
      @(posedge clk);
      rxPllLocked <= 1'b0;
      feed(6, 1'b1);
      chk_word("unlocked output", 16'h0000, {13'h0000, lastCode});
      @(posedge clk);
      rxPllLocked <= 1'b1;
      feed(6, 1'b1);
      chk_word("start code", 16'h0003, {13'h0000, lastCode});
   endtask
   // one corrupted character inside a loop marks that loop bad
   task automatic t_bad_loop();
      clear_cnt();
      feed(1, 1'b1);
      feed(1, 1'b0);
      lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      feed(520, 1'b1);
      chk_word("loop bad marks", 16'h0001, cnt[4][15:0]);
      chk_word("one mismatch", 16'h0001, cnt[1][15:0]);
      chk_word("no good mark", 16'h0000, cnt[2][15:0]);
   endtask
   task automatic t_mid_reset();
      @(posedge clk);
      resetn <= 1'b0;
      @(negedge clk);
      chk_bit("status bit", 1'b0, selftestStatusBit);
      chk_bit("tx1", 1'b0, txPrimaryDriverOn);
      chk_bit("reclk1", 1'b0, reclkPrimaryDriverOn);
      chk_bit("rate", 1'b1, rxClockRateSelect);
      @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 2'h0;
      regWrData = 16'h0000;
      rxChar = 10'h000;
      rxPllLocked = 1'b1;
      lfsr = 9'h1ff;
      repeat (7) @(posedge clk);
      t_reset_values();
      @(posedge clk);
      resetn <= 1'b1;
      t_boot();
      t_refused();
      t_drivers();
      t_rate();
      t_loop();
      t_abort();
      t_lock_loss();
      t_bad_loop();
      t_mid_reset();
      close_out();
   end
   initial begin
      repeat (6000) @(posedge clk);
      failCount++;
      close_out();
   end
endmodule

/* src/cls_device.sv */
`timescale 1ns/1ps
module cls_device (
   input wire logic clk,
   input wire logic resetn,
   cls_cfg_if.dev cfg,
   input wire logic [cls_pkg::CHAR_W-1:0] rxChar,
   input wire logic rxPllLocked,
   output logic [cls_pkg::CHAR_W-1:0] rxParallelOut,
   output logic selftestStatusBit,
   output logic rxChannelPowerOn,
   output logic txPrimaryDriverOn,
   output logic txSecondaryDriverOn,
   output logic txLogicOn,
   output logic reclkPrimaryDriverOn,
   output logic reclkSecondaryDriverOn,
   output logic reclkLogicOn,
   output logic rxClockRateSelect,
   output logic recoveredClockOutP,
   output logic recoveredClockOutN
);
   import cls_pkg::*;

   // configuration storage, write only
   logic [DATA_W-1:0] bank_r [NUM_BANKS];
   logic [NUM_BANKS-1:0] bankHit;
   wire writeActive = !cfg.latchWriteStrobeN;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_BANKS; gi++) begin : gBank
         // test addresses match no entry, so writes there are dropped
         assign bankHit[gi] = writeActive && (cfg.latchAddr == BANK_ADDR[gi]);
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               bank_r[gi] <= BANK_RESET[gi];
            end else if (bankHit[gi]) begin
               bank_r[gi] <= cfg.latchData;
            end
         end
      end
   endgenerate

   // field decode; banks 0..2 belong to the receive/reclock channel
   wire rateHalf = bank_r[RATE_IDX][RATE_BIT];
   wire rxPower = bank_r[RXDYN_IDX][RX_POWER_BIT];
   wire reclk1 = bank_r[RXDYN_IDX][RECLK1_BIT];
   wire reclk2 = bank_r[RXDYN_IDX][RECLK2_BIT];
   wire [1:0] selftestSel = bank_r[RXDYN_IDX][SELFTEST_LSB +: 2];
   wire tx1 = bank_r[TXDYN_IDX][TX1_BIT];
   wire tx2 = bank_r[TXDYN_IDX][TX2_BIT];

   // lock arrives from the analog PLL: two-stage synchroniser
   logic lockMeta_r;
   logic lockSync_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lockMeta_r <= 1'b0;
         lockSync_r <= 1'b0;
      end else begin
         lockMeta_r <= rxPllLocked;
         lockSync_r <= lockMeta_r;
      end
   end

   // checker runs only with the channel powered, locked and selected
   wire pllRunning = rxPower && lockSync_r;
   wire checkEnabled = rxPower && (selftestSel == SEL_ON);

   cls_chk_state_t state_r;
   cls_chk_state_t state_nxt;
   logic [LFSR_W-1:0] lfsr_r;
   logic [LFSR_W-1:0] lfsr_nxt;
   logic [8:0] charCnt_r;
   logic [8:0] charCnt_nxt;
   logic [4:0] diff_r;
   logic [4:0] diff_nxt;
   logic loopErr_r;
   logic loopErr_nxt;
   logic [2:0] code_nxt;

   wire [CHAR_W-1:0] expectChar = cls_lfsr_char(lfsr_r);
   wire [CHAR_W-1:0] seedChar = cls_lfsr_char(LFSR_SEED);
   wire charMatch = (rxChar == expectChar);
   wire seedSeen = (rxChar == seedChar);
   wire loopEnd = (charCnt_r == SEQ_LAST);
   wire abortNow = !charMatch && (diff_r == ABORT_DIFF);
   wire [4:0] diffUp = diff_r + 5'h1;
   wire [4:0] diffDown = (diff_r == 5'h0) ? 5'h0 : diff_r - 5'h1;

   always_comb begin
      state_nxt = state_r;
      lfsr_nxt = lfsr_r;
      charCnt_nxt = charCnt_r;
      diff_nxt = diff_r;
      loopErr_nxt = loopErr_r;
      code_nxt = ST_WAIT;
      if (!pllRunning || !checkEnabled) begin
         state_nxt = CHK_START;
         lfsr_nxt = LFSR_SEED;
         charCnt_nxt = 9'h0;
         diff_nxt = 5'h0;
         loopErr_nxt = 1'b0;
      end else begin
         unique case (state_r)
            CHK_START: begin
               state_nxt = CHK_WAIT;
               lfsr_nxt = LFSR_SEED;
               diff_nxt = 5'h0;
            end
            CHK_WAIT: begin
               diff_nxt = 5'h0;
               if (seedSeen) begin
                  // seed character taken as position 0 of the loop
                  state_nxt = CHK_COMPARE;
                  lfsr_nxt = cls_lfsr_next(LFSR_SEED);
                  charCnt_nxt = 9'h1;
                  loopErr_nxt = 1'b0;
               end
            end
            CHK_COMPARE: begin
               lfsr_nxt = cls_lfsr_next(lfsr_r);
               diff_nxt = charMatch ? diffDown : diffUp;
               if (abortNow) begin
                  state_nxt = CHK_WAIT;
                  lfsr_nxt = LFSR_SEED;
                  diff_nxt = 5'h0;
                  charCnt_nxt = 9'h0;
                  code_nxt = ST_MISS;
               end else if (loopEnd) begin
                  charCnt_nxt = 9'h0;
                  loopErr_nxt = 1'b0;
                  code_nxt = (loopErr_r || !charMatch) ? ST_LOOP_BAD : ST_LOOP_GOOD;
               end else begin
                  charCnt_nxt = charCnt_r + 9'h1;
                  loopErr_nxt = loopErr_r || !charMatch;
                  code_nxt = charMatch ? ST_MATCH : ST_MISS;
               end
            end
            default: begin
               state_nxt = CHK_START;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= CHK_START;
         lfsr_r <= LFSR_SEED;
         charCnt_r <= 9'h0;
         diff_r <= 5'h0;
         loopErr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         lfsr_r <= lfsr_nxt;
         charCnt_r <= charCnt_nxt;
         diff_r <= diff_nxt;
         loopErr_r <= loopErr_nxt;
      end
   end

   // output register: status replaces the two low data bits while checking
   logic [CHAR_W-1:0] parOut_r;
   logic statusBit_r;
   // data bit 0 carries the middle code bit, data bit 1 the low one
   wire [CHAR_W-1:0] parOut_nxt = checkEnabled ? {rxChar[CHAR_W-1:2], code_nxt[0], code_nxt[1]} : rxChar;
   wire statusBit_nxt = checkEnabled && code_nxt[2];

   // deserializer path keeps running whatever the reclocker does
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         parOut_r <= '0;
         statusBit_r <= 1'b0;
      end else begin
         parOut_r <= pllRunning ? parOut_nxt : '0;
         statusBit_r <= pllRunning ? statusBit_nxt : 1'b0;
      end
   end

   // power controls
   logic rxPower_r;
   logic tx1_r;
   logic tx2_r;
   logic txLogic_r;
   logic reclk1_r;
   logic reclk2_r;
   logic reclkLogic_r;
   logic rate_r;
   logic clkPhase_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxPower_r <= 1'b0;
         tx1_r <= 1'b0;
         tx2_r <= 1'b0;
         txLogic_r <= 1'b0;
         reclk1_r <= 1'b0;
         reclk2_r <= 1'b0;
         reclkLogic_r <= 1'b0;
         rate_r <= 1'b1;
         clkPhase_r <= 1'b0;
      end else begin
         rxPower_r <= rxPower;
         tx1_r <= tx1;
         tx2_r <= tx2;
         txLogic_r <= tx1 || tx2;
         reclk1_r <= reclk1;
         reclk2_r <= reclk2;
         reclkLogic_r <= rxPower && (reclk1 || reclk2);
         rate_r <= rateHalf;
         // half rate: toggle once per character; full rate: rest low
         clkPhase_r <= rateHalf ? !clkPhase_r : 1'b0;
      end
   end

   assign rxParallelOut = parOut_r;
   assign selftestStatusBit = statusBit_r;
   assign rxChannelPowerOn = rxPower_r;
   assign txPrimaryDriverOn = tx1_r;
   assign txSecondaryDriverOn = tx2_r;
   assign txLogicOn = txLogic_r;
   assign reclkPrimaryDriverOn = reclk1_r;
   assign reclkSecondaryDriverOn = reclk2_r;
   assign reclkLogicOn = reclkLogic_r;
   assign rxClockRateSelect = rate_r;
   assign recoveredClockOutP = clkPhase_r;
   assign recoveredClockOutN = rate_r ? !clkPhase_r : 1'b0;
endmodule

/* src/cls_host.sv */
`timescale 1ns/1ps
module cls_host (
   input wire logic clk,
   input wire logic resetn,
   cls_cfg_if.host cfg,
   input wire logic [1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   output logic jtagResetN
);
   import cls_pkg::*;

   cls_host_state_t state_r;
   logic [3:0] jtagCnt_r;
   logic jtagDone_r;
   logic [1:0] bootIdx_r;
   logic bootDone_r;
   logic refused_r;
   logic [9:0] last_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] data_r;
   logic strobeN_r;
   logic [15:0] rdData_r;

   wire idle = (state_r == HW_IDLE);
   wire bootStart = idle && jtagDone_r && !bootDone_r;
   wire swWrite = regWr && (regAddr == HREG_WRITE);
   wire swAccept = swWrite && idle && bootDone_r;
   wire swRefuse = swWrite && !swAccept;
   wire [9:0] bootWord = BOOT_TABLE[bootIdx_r];
   wire [9:0] launchWord = bootStart ? bootWord : regWrData[9:0];
   wire launch = bootStart || swAccept;
   wire [DATA_W-1:0] fixedData = (launchWord[DATA_W-1:0] & ~FIX_MASK) | FIX_VALUE;
   wire statusRead = regRd && (regAddr == HREG_STATUS);
   wire [15:0] statusWord = {13'h0, refused_r, bootDone_r, !idle};
   wire [15:0] rdMux = (regAddr == HREG_STATUS) ? statusWord :
                       (regAddr == HREG_LAST) ? {6'h0, last_r} : 16'h0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         jtagCnt_r <= 4'h0;
         jtagDone_r <= 1'b0;
      end else if (!jtagDone_r) begin
         jtagCnt_r <= jtagCnt_r + 4'h1;
         jtagDone_r <= (jtagCnt_r == JTAG_RESET_CYCLES - 4'h1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= HW_IDLE;
         addr_r <= '0;
         data_r <= '0;
         strobeN_r <= 1'b1;
         last_r <= '0;
      end else begin
         unique case (state_r)
            HW_IDLE: begin
               if (launch) begin
                  state_r <= HW_SETUP;
                  addr_r <= launchWord[9:7];
                  data_r <= fixedData;
                  last_r <= {launchWord[9:7], fixedData};
               end
            end
            HW_SETUP: begin
               state_r <= HW_STROBE;
               strobeN_r <= 1'b0;
            end
            HW_STROBE: begin
               state_r <= HW_HOLD;
               strobeN_r <= 1'b1;
            end
            HW_HOLD: begin
               state_r <= HW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bootIdx_r <= 2'h0;
         bootDone_r <= 1'b0;
      end else if (bootStart) begin
         bootIdx_r <= bootIdx_r + 2'h1;
         bootDone_r <= (bootIdx_r == 2'(BOOT_LEN - 1));
      end
   end

   // a refused write in the clearing cycle still sets the flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         refused_r <= 1'b0;
         rdData_r <= 16'h0;
      end else begin
         refused_r <= swRefuse || (refused_r && !statusRead);
         rdData_r <= regRd ? rdMux : 16'h0;
      end
   end

   assign cfg.latchAddr = addr_r;
   assign cfg.latchData = data_r;
   assign cfg.latchWriteStrobeN = strobeN_r;
   assign regRdData = rdData_r;
   assign jtagResetN = jtagDone_r;
endmodule
